// ===== core/itix_pkg.sv
// Constants, field layout and opcode encodings for the indicator test and index execution block.
package itix_pkg;

    // ************************************************************
    // Word and field layout (word bit 35 is the sign position)
    // ************************************************************
    localparam int WORD_W = 36;
    localparam int XR_W = 15;
    localparam int HALF_W = 18;
    localparam int NUM_XR = 3;
    localparam int SIGN_BIT = 35;
    localparam int OPC_LSB = 24;
    localparam int OPC_W = 11;
    localparam int PFX_LSB = 33;
    localparam int PFX_W = 2;
    localparam int DEC_LSB = 18;
    localparam int TAG_LSB = 15;
    localparam int TAG_W = 3;
    localparam int ADDR_LSB = 0;
    localparam int CF_LSB = 0;

    // ************************************************************
    // Operation codes (sign selects between paired operations)
    // ************************************************************
    localparam logic [OPC_W-1:0] OPC_FULL_ON = 11'h126;
    localparam logic [OPC_W-1:0] OPC_FULL_OFF = 11'h124;
    localparam logic [OPC_W-1:0] OPC_HALF_ON = 11'h02e;
    localparam logic [OPC_W-1:0] OPC_HALF_OFF = 11'h02c;
    localparam logic [OPC_W-1:0] OPC_LINK = 11'h03c;
    localparam logic [OPC_W-1:0] OPC_PLACE = 11'h1dc;
    localparam logic [OPC_W-1:0] OPC_PLACE_CPL = 11'h1df;
    localparam logic [PFX_W-1:0] PFX_NONE = 2'h0;
    localparam logic [PFX_W-1:0] PFX_INCR = 2'h1;
    localparam logic [PFX_W-1:0] PFX_LOOP = 2'h2;
    localparam logic [PFX_W-1:0] PFX_CMP = 2'h3;

    // ************************************************************
    // Counter steps and reset values
    // ************************************************************
    localparam logic [XR_W-1:0] IC_STEP = 15'h0001;
    localparam logic [XR_W-1:0] SKIP_STEP = 15'h0002;
    localparam logic [XR_W-1:0] XR_RESET = 15'h0000;
    localparam logic [WORD_W-1:0] WORD_RESET = 36'h000000000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ICYC = 3'h1,
        ST_ECYC = 3'h3,
        ST_LOG1 = 3'h2,
        ST_LOG2 = 3'h6
    } itix_state_t;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_FULL_WORD_ON_TEST,
        OP_FULL_WORD_OFF_TEST,
        OP_RIGHT_HALF_ON_TEST,
        OP_LEFT_HALF_ON_TEST,
        OP_RIGHT_HALF_OFF_TEST,
        OP_LEFT_HALF_OFF_TEST,
        OP_INCREMENT_AND_JUMP,
        OP_COUNT_DOWN_LOOP_JUMP,
        OP_COUNT_DOWN_EXIT_JUMP,
        OP_JUMP_IF_INDEX_ABOVE,
        OP_JUMP_IF_INDEX_AT_OR_BELOW,
        OP_JUMP_AND_LINK_INDEX,
        OP_LOAD_INDEX_FROM_ADDR_FIELD,
        OP_LOAD_INDEX_FROM_COUNT_FIELD,
        OP_LOAD_INDEX_NEGATED_ADDR
    } itix_op_t;

    function automatic logic [XR_W-1:0] f_addr(input logic [WORD_W-1:0] w);
        f_addr = w[ADDR_LSB +: XR_W];
    endfunction

    function automatic logic [XR_W-1:0] f_dec(input logic [WORD_W-1:0] w);
        f_dec = w[DEC_LSB +: XR_W];
    endfunction

    function automatic logic [HALF_W-1:0] f_cf(input logic [WORD_W-1:0] w);
        f_cf = w[CF_LSB +: HALF_W];
    endfunction

endpackage

// ===== core/itix_adder.sv
// Ripple-style adder slice with carry in and carry out of the top position.
`timescale 1ns/1ps
module itix_adder #(
    parameter int WIDTH = 15
) (
    input wire logic [WIDTH-1:0] a_i,
    input wire logic [WIDTH-1:0] b_i,
    input wire logic carry_i,
    output wire logic [WIDTH-1:0] sum_o,
    output wire logic carry_o
);
    logic [WIDTH:0] full_w;

    assign full_w = {1'b0, a_i} + {1'b0, b_i} + {{WIDTH{1'b0}}, carry_i};
    assign sum_o = full_w[WIDTH-1:0];
    assign carry_o = full_w[WIDTH];
endmodule

// ===== core/itix_exec.sv
// Execution sequencer for indicator tests and index register transfers.
`timescale 1ns/1ps
// Functional notes
// - Full-word on-test skips when every test-word one meets an indicator one.
// - Full-word tests take one storage fetch cycle then two logic cycles.
// - Complemented test word ORed with indicators; carry out of top means skip.
// - Full-word off-test ORs with complemented indicators instead.
// - Right-half on-test compares control field against indicator bits 18-35.
// - Left-half on-test compares control field against indicator bits 0-17.
// - Right-half off-test skips when control field ones meet indicator zeros.
// - Left-half off-test as above on bits 0-17; field and indicators untouched.
// - Three index registers of fifteen bits each.
// - Tag bits 18-20 pick any set of index registers during the I cycle.
// - Index output reaches adders complemented with carry in, giving negation.
// - Increment-and-jump adds decrement to index and always jumps.
// - Loop jump: index above decrement reduces and jumps, else falls through.
// - No carry from decrement plus negated index means index is greater.
// - Exit jump: index above reduces and falls through, else jumps unreduced.
// - Jump-if-above never writes the index register.
// - Jump-if-at-or-below jumps when index not above, index unchanged.
// - Jump-and-link loads negated instruction location then jumps.
// - Load from address field copies accumulator bits 21-35 true.
// - Load from count field copies accumulator bits 3-17 true.
// - Load negated address loads two's complement of accumulator bits 21-35.
// - Address field sits in word bits 21-35.
// - Decrement field sits in word bits 3-17.
module itix_exec (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [itix_pkg::WORD_W-1:0] storage_bus_i,
    input wire logic [itix_pkg::XR_W-1:0] ic_i,
    input wire logic [itix_pkg::WORD_W-1:0] acc_i,
    input wire logic [itix_pkg::WORD_W-1:0] ind_i,
    output logic busy_o,
    output logic mem_rd_o,
    output logic [itix_pkg::XR_W-1:0] mem_addr_o,
    output logic done_o,
    output logic [itix_pkg::XR_W-1:0] next_ic_o,
    output logic [itix_pkg::XR_W-1:0] index_reg_a_o,
    output logic [itix_pkg::XR_W-1:0] index_reg_b_o,
    output logic [itix_pkg::XR_W-1:0] index_reg_c_o
);
    import itix_pkg::*;

    // ************************************************************
    // State and datapath registers
    // ************************************************************
    itix_state_t state_q, state_d;
    itix_op_t op_q;
    logic [WORD_W-1:0] instr_q, acc_q, ind_q, test_q, storage_register_q;
    logic [TAG_W-1:0] tag_q;
    logic [XR_W-1:0] ic_q, next_ic_q, mem_addr_q;
    logic [XR_W-1:0] index_reg_q [NUM_XR];
    logic done_q, mem_rd_q, busy_q;

    // ************************************************************
    // Instruction decode from the storage bus
    // ************************************************************
    logic sign_w;
    logic [OPC_W-1:0] opc_w;
    logic [PFX_W-1:0] pfx_w;
    itix_op_t op_dec_w;

    assign sign_w = storage_bus_i[SIGN_BIT];
    assign opc_w = storage_bus_i[OPC_LSB +: OPC_W];
    assign pfx_w = storage_bus_i[PFX_LSB +: PFX_W];
    assign op_dec_w =
        (pfx_w == PFX_INCR && !sign_w) ? OP_INCREMENT_AND_JUMP :
        (pfx_w == PFX_LOOP) ? (sign_w ? OP_COUNT_DOWN_EXIT_JUMP : OP_COUNT_DOWN_LOOP_JUMP) :
        (pfx_w == PFX_CMP) ? (sign_w ? OP_JUMP_IF_INDEX_AT_OR_BELOW : OP_JUMP_IF_INDEX_ABOVE) :
        (pfx_w != PFX_NONE) ? OP_NONE :
        (opc_w == OPC_FULL_ON && !sign_w) ? OP_FULL_WORD_ON_TEST :
        (opc_w == OPC_FULL_OFF && !sign_w) ? OP_FULL_WORD_OFF_TEST :
        (opc_w == OPC_HALF_ON) ? (sign_w ? OP_LEFT_HALF_ON_TEST : OP_RIGHT_HALF_ON_TEST) :
        (opc_w == OPC_HALF_OFF) ? (sign_w ? OP_LEFT_HALF_OFF_TEST : OP_RIGHT_HALF_OFF_TEST) :
        (opc_w == OPC_LINK && !sign_w) ? OP_JUMP_AND_LINK_INDEX :
        (opc_w == OPC_PLACE) ? (sign_w ? OP_LOAD_INDEX_FROM_COUNT_FIELD : OP_LOAD_INDEX_FROM_ADDR_FIELD) :
        (opc_w == OPC_PLACE_CPL && !sign_w) ? OP_LOAD_INDEX_NEGATED_ADDR : OP_NONE;

    // ************************************************************
    // Operation classes
    // ************************************************************
    logic is_full_w, is_half_w, is_off_w, is_left_w, is_right_w, is_index_l_w, is_place_w;

    assign is_full_w = (op_q == OP_FULL_WORD_ON_TEST) || (op_q == OP_FULL_WORD_OFF_TEST);
    assign is_left_w = (op_q == OP_LEFT_HALF_ON_TEST) || (op_q == OP_LEFT_HALF_OFF_TEST);
    assign is_right_w = (op_q == OP_RIGHT_HALF_ON_TEST) || (op_q == OP_RIGHT_HALF_OFF_TEST);
    assign is_half_w = is_left_w || is_right_w;
    assign is_off_w = (op_q == OP_FULL_WORD_OFF_TEST) || (op_q == OP_RIGHT_HALF_OFF_TEST) ||
                      (op_q == OP_LEFT_HALF_OFF_TEST);
    assign is_index_l_w = (op_q == OP_INCREMENT_AND_JUMP) || (op_q == OP_COUNT_DOWN_LOOP_JUMP) ||
                          (op_q == OP_COUNT_DOWN_EXIT_JUMP) || (op_q == OP_JUMP_IF_INDEX_ABOVE) ||
                          (op_q == OP_JUMP_IF_INDEX_AT_OR_BELOW) || (op_q == OP_JUMP_AND_LINK_INDEX);
    assign is_place_w = (op_q == OP_LOAD_INDEX_FROM_ADDR_FIELD) ||
                        (op_q == OP_LOAD_INDEX_FROM_COUNT_FIELD) || (op_q == OP_LOAD_INDEX_NEGATED_ADDR);

    // ************************************************************
    // Indicator test datapath
    // ************************************************************
    logic [WORD_W-1:0] mask_w, ind_term_w, or_w;
    logic all_ones_w;

    assign mask_w = is_full_w ? test_q :
                    is_left_w ? {f_cf(instr_q), {HALF_W{1'b0}}} :
                    {{HALF_W{1'b0}}, f_cf(instr_q)};
    assign ind_term_w = is_off_w ? ~ind_q : ind_q;
    assign or_w = ~mask_w | ind_term_w;

    // carry out of the top position marks all ones.
    itix_adder #(
        .WIDTH(WORD_W)
    ) u_ones_adder (
        .a_i(storage_register_q),
        .b_i(WORD_RESET),
        .carry_i(1'b1),
        .sum_o(),
        .carry_o(all_ones_w)
    );

    // ************************************************************
    // Index datapath
    // ************************************************************
    logic [XR_W-1:0] dec_w, addr_w, xsel_w, xr_cpl_w, cmp_sum_w;
    logic [XR_W-1:0] b_a_w, b_b_w, b_sum_w, xr_wr_val_w;
    logic cmp_carry_w, b_cin_w, x_above_w, xr_wr_w;

    assign dec_w = f_dec(instr_q);
    assign addr_w = f_addr(instr_q);
    // Several selected registers are read as the OR of their contents.
    assign xsel_w = ({XR_W{tag_q[0]}} & index_reg_q[0]) | ({XR_W{tag_q[1]}} & index_reg_q[1]) |
                    ({XR_W{tag_q[2]}} & index_reg_q[2]);
    assign xr_cpl_w = ~xsel_w;

    itix_adder #(
        .WIDTH(XR_W)
    ) u_cmp_adder (
        .a_i(dec_w),
        .b_i(xr_cpl_w),
        .carry_i(1'b1),
        .sum_o(cmp_sum_w),
        .carry_o(cmp_carry_w)
    );
    assign x_above_w = ~cmp_carry_w;

    // The second pass re-complements; this mirrors cycling a value back through the adders.
    assign b_a_w = (op_q == OP_INCREMENT_AND_JUMP) ? dec_w :
                   (op_q == OP_COUNT_DOWN_LOOP_JUMP || op_q == OP_COUNT_DOWN_EXIT_JUMP) ? ~cmp_sum_w :
                   (op_q == OP_JUMP_AND_LINK_INDEX) ? ~ic_q :
                   (op_q == OP_LOAD_INDEX_NEGATED_ADDR) ? ~f_addr(acc_q) : XR_RESET;
    // true index from the complemented output
    assign b_b_w = (op_q == OP_INCREMENT_AND_JUMP) ? ~xr_cpl_w : XR_RESET;
    assign b_cin_w = (op_q != OP_INCREMENT_AND_JUMP);

    itix_adder #(
        .WIDTH(XR_W)
    ) u_cycle_adder (
        .a_i(b_a_w),
        .b_i(b_b_w),
        .carry_i(b_cin_w),
        .sum_o(b_sum_w),
        .carry_o()
    );

    assign xr_wr_val_w = (op_q == OP_LOAD_INDEX_FROM_ADDR_FIELD) ? f_addr(acc_q) :
                         (op_q == OP_LOAD_INDEX_FROM_COUNT_FIELD) ? f_dec(acc_q) : b_sum_w;
    // write on place, increment and link; loop and exit write only where reduction is due
    assign xr_wr_w = (state_q == ST_ICYC && is_place_w) ||
                     (state_q == ST_LOG1 && ((op_q == OP_INCREMENT_AND_JUMP) ||
                      (op_q == OP_JUMP_AND_LINK_INDEX) ||
                      ((op_q == OP_COUNT_DOWN_LOOP_JUMP || op_q == OP_COUNT_DOWN_EXIT_JUMP) && x_above_w)));

    // ************************************************************
    // Sequencing and next location
    // ************************************************************
    logic [XR_W-1:0] ic_plus1_w, ic_plus2_w, next_ic_w;
    logic jump_w, finish_w;

    assign ic_plus1_w = ic_q + IC_STEP;
    assign ic_plus2_w = ic_q + SKIP_STEP;
    assign jump_w = (op_q == OP_INCREMENT_AND_JUMP) || (op_q == OP_JUMP_AND_LINK_INDEX) ||
                    ((op_q == OP_COUNT_DOWN_LOOP_JUMP || op_q == OP_JUMP_IF_INDEX_ABOVE) && x_above_w) ||
                    ((op_q == OP_COUNT_DOWN_EXIT_JUMP || op_q == OP_JUMP_IF_INDEX_AT_OR_BELOW) && !x_above_w);
    assign next_ic_w = (state_q == ST_LOG2) ? (all_ones_w ? ic_plus2_w : ic_plus1_w) :
                       (state_q == ST_LOG1 && jump_w) ? addr_w : ic_plus1_w;
    assign finish_w = (state_q == ST_ICYC && !is_full_w && !is_half_w && !is_index_l_w) ||
                      (state_q == ST_LOG1 && is_index_l_w) || (state_q == ST_LOG2);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_i) begin
                    state_d = ST_ICYC;
                end
            end
            ST_ICYC: begin
                if (is_full_w) begin
                    state_d = ST_ECYC;
                end else if (is_half_w || is_index_l_w) begin
                    state_d = ST_LOG1;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_ECYC: state_d = ST_LOG1;
            ST_LOG1: state_d = (is_full_w || is_half_w) ? ST_LOG2 : ST_IDLE;
            ST_LOG2: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Indicators and accumulator are sampled once at start and never written back.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            op_q <= OP_NONE;
            instr_q <= WORD_RESET;
            acc_q <= WORD_RESET;
            ind_q <= WORD_RESET;
            ic_q <= XR_RESET;
            tag_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && start_i) begin
                op_q <= op_dec_w;
                instr_q <= storage_bus_i;
                acc_q <= acc_i;
                ind_q <= ind_i;
                ic_q <= ic_i;
                // tag triggers set from the storage bus
                tag_q <= storage_bus_i[TAG_LSB +: TAG_W];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            test_q <= WORD_RESET;
            storage_register_q <= WORD_RESET;
            mem_rd_q <= 1'b0;
            busy_q <= 1'b0;
            mem_addr_q <= XR_RESET;
            done_q <= 1'b0;
            next_ic_q <= XR_RESET;
        end else begin
            mem_rd_q <= (state_d == ST_ECYC);
            // Busy is registered from the next state so that it leaves a flip-flop.
            busy_q <= (state_d != ST_IDLE);
            if (state_q == ST_ICYC) begin
                mem_addr_q <= addr_w;
            end
            if (state_q == ST_ECYC) begin
                test_q <= storage_bus_i;
            end
            if (state_q == ST_LOG1) begin
                storage_register_q <= or_w;
            end
            done_q <= finish_w;
            if (finish_w) begin
                next_ic_q <= next_ic_w;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < NUM_XR; i++) begin
            if (rst_i) begin
                index_reg_q[i] <= XR_RESET;
            end else if (xr_wr_w && tag_q[i]) begin
                index_reg_q[i] <= xr_wr_val_w;
            end
        end
    end

    assign busy_o = busy_q;
    assign mem_rd_o = mem_rd_q;
    assign mem_addr_o = mem_addr_q;
    assign done_o = done_q;
    assign next_ic_o = next_ic_q;
    assign index_reg_a_o = index_reg_q[0];
    assign index_reg_b_o = index_reg_q[1];
    assign index_reg_c_o = index_reg_q[2];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    full_seq_a: assert property ((state_q == ST_IDLE && start_i && op_dec_w == OP_FULL_WORD_ON_TEST) |=>
        state_q == ST_ICYC ##1 state_q == ST_ECYC && mem_rd_o ##1 state_q == ST_LOG1 ##1 state_q == ST_LOG2 ##1 done_o)
        else $error("full test sequence wrong");
    on_skip_a: assert property ((state_q == ST_LOG2 && op_q == OP_FULL_WORD_ON_TEST) |=>
        next_ic_o == ((((test_q & ~ind_q) == WORD_RESET)) ? ic_q + SKIP_STEP : ic_q + IC_STEP))
        else $error("full on test skip wrong");
    off_skip_a: assert property ((state_q == ST_LOG2 && op_q == OP_FULL_WORD_OFF_TEST) |=>
        next_ic_o == ((((test_q & ind_q) == WORD_RESET)) ? ic_q + SKIP_STEP : ic_q + IC_STEP))
        else $error("full off test skip wrong");
    left_on_a: assert property ((state_q == ST_LOG2 && op_q == OP_LEFT_HALF_ON_TEST) |=>
        next_ic_o == (((f_cf(instr_q) & ~ind_q[WORD_W-1 -: HALF_W]) == '0) ? ic_q + SKIP_STEP : ic_q + IC_STEP))
        else $error("left half on test wrong");
    right_off_a: assert property ((state_q == ST_LOG2 && op_q == OP_RIGHT_HALF_OFF_TEST) |=>
        next_ic_o == (((f_cf(instr_q) & ind_q[HALF_W-1:0]) == '0) ? ic_q + SKIP_STEP : ic_q + IC_STEP))
        else $error("right half off test wrong");
    loop_reduce_a: assert property ((state_q == ST_LOG1 && op_q == OP_COUNT_DOWN_LOOP_JUMP &&
        xsel_w > dec_w) |=> next_ic_o == addr_w && xsel_w == $past(xsel_w - dec_w))
        else $error("loop jump reduce wrong");
    exit_keep_a: assert property ((state_q == ST_LOG1 && op_q == OP_COUNT_DOWN_EXIT_JUMP &&
        xsel_w <= dec_w) |=> next_ic_o == addr_w && $stable(xsel_w))
        else $error("exit jump wrong");
    above_nowrite_a: assert property ((state_q == ST_LOG1 && op_q == OP_JUMP_IF_INDEX_ABOVE) |=>
        $stable(index_reg_a_o) && $stable(index_reg_b_o) && $stable(index_reg_c_o))
        else $error("index written by compare jump");
    link_value_a: assert property ((state_q == ST_LOG1 && op_q == OP_JUMP_AND_LINK_INDEX && tag_q != '0) |=>
        xsel_w == XR_W'(-ic_q) && next_ic_o == addr_w)
        else $error("link value wrong");
    place_addr_a: assert property ((state_q == ST_ICYC && op_q == OP_LOAD_INDEX_FROM_ADDR_FIELD &&
        tag_q != '0) |=> xsel_w == f_addr(acc_q) ##1 1'b1)
        else $error("address place wrong");
    place_neg_a: assert property ((state_q == ST_ICYC && op_q == OP_LOAD_INDEX_NEGATED_ADDR &&
        tag_q != '0) |=> xsel_w == XR_W'(-f_addr(acc_q)))
        else $error("negated place wrong");

    on_skip_c: cover property (state_q == ST_LOG2 && op_q == OP_FULL_WORD_ON_TEST && all_ones_w);
    loop_taken_c: cover property (state_q == ST_LOG1 && op_q == OP_COUNT_DOWN_LOOP_JUMP && x_above_w);
    link_c: cover property (state_q == ST_LOG1 && op_q == OP_JUMP_AND_LINK_INDEX);
    incr_c: cover property (state_q == ST_LOG1 && op_q == OP_INCREMENT_AND_JUMP && tag_q == 3'h3);
endmodule

// ===== verification/itix_exec_bench.sv
// Self-checking bench for the indicator test and index execution block.
`timescale 1ns/1ps
module itix_exec_bench;
import itix_pkg::*;
logic core_clk_i;
logic rst_i = 1'b1;
logic start_i = 1'b0;
logic [WORD_W-1:0] storage_bus_i = '0;
logic [XR_W-1:0] ic_i = '0;
logic [WORD_W-1:0] acc_i = '0;
logic [WORD_W-1:0] ind_i = '0;
logic busy_o, mem_rd_o, done_o;
logic [XR_W-1:0] mem_addr_o, next_ic_o, xa, xb, xc;
logic [XR_W-1:0] xr [3];
int failures = 0;
int num_checks = 0;

itix_exec dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i), .storage_bus_i(storage_bus_i),
    .ic_i(ic_i), .acc_i(acc_i), .ind_i(ind_i), .busy_o(busy_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .done_o(done_o), .next_ic_o(next_ic_o), .index_reg_a_o(xa), .index_reg_b_o(xb), .index_reg_c_o(xc));

initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
end

task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask

task automatic check(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
        $display("BAD %s expected %h seen %h", what, exp, got);
        failures++;
    end
endtask

function automatic logic [WORD_W-1:0] rnd();
    logic [63:0] v;
    v = {$urandom, $urandom};
    return v[WORD_W-1:0];
endfunction

// Several tags select the OR of their registers.
function automatic logic [XR_W-1:0] xsel(input logic [2:0] tg);
    return (tg[0] ? xr[0] : '0) | (tg[1] ? xr[1] : '0) | (tg[2] ? xr[2] : '0);
endfunction

// ************************************************************
// Reference model and one instruction on the ports
// ************************************************************
task automatic run(input logic [WORD_W-1:0] w, input logic [XR_W-1:0] ic, input logic [WORD_W-1:0] ac,
    input logic [WORD_W-1:0] ind, input logic [WORD_W-1:0] tw, input bit spur);
    int cnt;
    int lat;
    int rdn;
    logic [XR_W-1:0] x, d, a, nic, nv;
    logic [WORD_W-1:0] m, t;
    logic wr, full, half, on, above, skip;
    x = xsel(w[17:15]);
    d = w[32:18];
    a = w[14:0];
    above = x > d;
    full = !w[35] && (w[34:24] == OPC_FULL_ON || w[34:24] == OPC_FULL_OFF);
    half = w[34:24] == OPC_HALF_ON || w[34:24] == OPC_HALF_OFF;
    on = w[34:24] == OPC_FULL_ON || w[34:24] == OPC_HALF_ON;
    m = full ? ind : {18'h00000, w[35] ? ind[35:18] : ind[17:0]};
    t = full ? tw : {18'h00000, w[17:0]};
    skip = (full || half) && ((t & (on ? ~m : m)) == '0);
    lat = full ? 5 : half ? 4 : 2;
    nic = skip ? ic + 15'h0002 : ic + 15'h0001;
    wr = 1'b0;
    nv = '0;
    // A negative increment prefix is not an operation of this block and finishes as unknown.
    if (w[34:33] != PFX_NONE && !(w[34:33] == PFX_INCR && w[35])) begin
        lat = 3;
        wr = (w[34:33] == PFX_INCR) || (w[34:33] == PFX_LOOP && above);
        nv = (w[34:33] == PFX_INCR) ? x + d : x - d;
        if (w[34:33] == PFX_INCR || above != w[35])
            nic = a;
    end else if (!w[35] && w[34:24] == OPC_LINK) begin
        lat = 3;
        wr = 1'b1;
        nv = 15'h0000 - ic;
        nic = a;
    end else if (w[34:24] == OPC_PLACE || (!w[35] && w[34:24] == OPC_PLACE_CPL)) begin
        wr = 1'b1;
        nv = w[35] ? ac[32:18] : w[24] ? 15'h0000 - ac[14:0] : ac[14:0];
    end
    start_i = 1'b1;
    storage_bus_i = w;
    ic_i = ic;
    acc_i = ac;
    ind_i = ind;
    cnt = 0;
    rdn = 0;
    while (cnt < 12) begin
        @(negedge core_clk_i);
        cnt++;
        if (done_o === 1'b1)
            break;
        check("busy", 1, busy_o);
        start_i = spur && cnt == 1;
        // The bus only carries the test word while the read is asked for.
        storage_bus_i = mem_rd_o ? tw : ~tw;
        if (mem_rd_o === 1'b1) begin
            rdn++;
            check("mem_addr", a, mem_addr_o);
        end
    end
    if (cnt >= 12) begin
        failures++;
        end_of_test();
    end
    check("latency", lat, cnt);
    check("mem_rd_cycles", full, rdn);
    check("busy_at_done", '0, busy_o);
    check("next_ic", nic, next_ic_o);
    for (int j = 0; j < 3; j++)
        if (wr && w[15+j])
            xr[j] = nv;
    check("index_reg_a", xr[0], xa);
    check("index_reg_b", xr[1], xb);
    check("index_reg_c", xr[2], xc);
endtask

// ************************************************************
// Main sequence
// ************************************************************
initial begin
    int k;
    logic [WORD_W-1:0] w, ac, ind, t, m;
    logic [XR_W-1:0] ic, x;
    k = $urandom(18588);
    for (int j = 0; j < 3; j++)
        xr[j] = '0;
    repeat (16) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check("reset_index", '0, {xa, xb});
    check("reset_state", '0, {xc, next_ic_o, done_o, busy_o, mem_rd_o});
    rst_i = 1'b0;
    for (int i = 0; i < 480; i++) begin
        k = i % 16;
        w = rnd();
        ac = rnd();
        ind = rnd();
        t = rnd();
        ic = (i % 7 == 0) ? 15'h7fff : t[14:0];
        m = (k == 3 || k == 5) ? ind >> 18 : ind;
        t = rnd() & ((i % 3 == 0) ? m : (i % 3 == 1) ? ~m : '1);
        x = xsel(w[17:15]);
        // Equal index and count is the boundary between jump and fall-through.
        case (k)
            0, 1: w = {1'b0, k == 0 ? OPC_FULL_ON : OPC_FULL_OFF, w[23:0]};
            2, 3, 4, 5: w = {k == 3 || k == 5, k < 4 ? OPC_HALF_ON : OPC_HALF_OFF, w[23:18], t[17:0]};
            6, 7, 8, 9, 10: w = {k == 8 || k == 10 || (k == 6 && i % 3 == 2),
                k < 7 ? PFX_INCR : k < 9 ? PFX_LOOP : PFX_CMP,
                (i % 3 == 0) ? x : w[32:18], w[17:0]};
            11: w[35:24] = {1'b0, OPC_LINK};
            12, 13: w[35:24] = {k == 13, OPC_PLACE};
            14: w[35:24] = {1'b0, OPC_PLACE_CPL};
            default: w[35:24] = 12'h000;
        endcase
        run(w, ic, ac, ind, t, i % 5 == 0);
    end
    end_of_test();
end
endmodule
